// [hw/esmc_event_ctrl.sv]
// Event status, interrupt request and miscellaneous control logic behind an APB slave.
//
// Operation
// - Polarity bit 0 gives an active-low request pin, 1 active-high; resets to 0.
// - In active-low mode the pin floats when inactive and is never driven high.
// - Code memory bit 0 selects ROM, 1 selects RAM; resets to 0.
// - Soft reset bit holds the microcontroller in reset until written back to 0.
// - A raw status bit clears only when 1 is written to its clear bit.
// - Receive-complete sets only after a full 10-bit antenna word arrives.
// - A truncated antenna reply sets receive-timeout, never receive-complete.
// - Receive-timeout sets when 100 ms pass after transmission without a full reply.
// - A truncated-reply timeout also sets the antenna receive-error flag.
// - Transmit-complete sets when a word transmission to the antenna finishes.
// - Tuner error sets when the tuner gives no answer or a NACK.
// - Tuner done sets only for a transfer that finished without error.
// - Raw status is read-only to the host and resets to all zeros.
// - Reserved bits read as zero and ignore writes.
// - Each status bit is raw AND mask and drops when raw drops.
// - The request pin is asserted while any unmasked status bit is set.
// - Mask bit 1 enables, 0 disables; resets disabled; raw bits still set.
`default_nettype none
module esmc_event_ctrl
#(
  parameter int unsigned CYC_PER_MS = esmc_pkg::CLK_HZ / esmc_pkg::MS_PER_SECOND
)
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire esmc_pkg::esmc_apb_req_s apbReq,
  output var logic [esmc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output var logic pslverr,
  input wire esmc_pkg::esmc_evt_s evtIn,
  output var logic irqOutPin,
  output var logic irqOutPinOe,
  output logic codeMemorySel,
  output logic microSoftReset,
  output logic antRxError
);
  import esmc_pkg::*;

  localparam int DIV_W = (CYC_PER_MS > 1) ? $clog2(CYC_PER_MS) : 1;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CYC_PER_MS - 1);
  localparam logic [TICK_CNT_W-1:0] TICK_LAST = TICK_CNT_W'(RX_TIMEOUT_MS - 1);
  localparam logic [RX_CNT_W-1:0] BIT_LAST = RX_CNT_W'(RX_WORD_BITS - 1);
  localparam logic [RX_CNT_W-1:0] BIT_NONE = '0;

  logic [REG_W-1:0] miscControl, eventRawStatus, eventMask, eventStatus;
  logic [REG_W-1:0] eventSet, next_eventRawStatus, rdMux;
  logic ackPhase, accessCycle, wrEn, addrHit;
  logic hitMisc, hitAnt, hitRaw, hitStat, hitMask, hitClr;
  logic [7:0] regIdx;
  esmc_rx_state_e rxState;
  logic [RX_CNT_W-1:0] rxBitCount;
  logic [DIV_W-1:0] msDiv;
  logic [TICK_CNT_W-1:0] msCount;
  logic msTick, timeoutHit, irqActive;
  logic rxCompleteEv, rxTimeoutEv, rxTruncEv, tunerDoneEv, tunerErrorEv, antClearErr;

  // The slave inserts one wait state so that read data comes from a flip-flop.
  assign accessCycle = apbReq.psel & apbReq.penable;
  assign pready = accessCycle & ackPhase;
  assign wrEn = pready & apbReq.pwrite & addrHit;
  assign regIdx = apbReq.paddr[9:2];

  always_comb
  begin
    hitMisc = 1'b0;
    hitAnt = 1'b0;
    hitRaw = 1'b0;
    hitStat = 1'b0;
    hitMask = 1'b0;
    hitClr = 1'b0;
    if (apbReq.paddr[1:0] != WORD_ALIGN || apbReq.paddr[ADDR_W-1:10] != '0)
    begin
      hitMisc = 1'b0;
    end
    else if (regIdx == IDX_MISC_CONTROL)
    begin
      hitMisc = 1'b1;
    end
    else if (regIdx == IDX_ANT_STATUS)
    begin
      hitAnt = 1'b1;
    end
    else if (regIdx == IDX_EVENT_RAW_STATUS)
    begin
      hitRaw = 1'b1;
    end
    else if (regIdx == IDX_EVENT_STATUS)
    begin
      hitStat = 1'b1;
    end
    else if (regIdx == IDX_EVENT_MASK)
    begin
      hitMask = 1'b1;
    end
    else if (regIdx == IDX_EVENT_CLEAR)
    begin
      hitClr = 1'b1;
    end
  end

  assign addrHit = hitMisc | hitAnt | hitRaw | hitStat | hitMask | hitClr;

  // Unused and reserved bits read as zero; the clear register is write-only.
  always_comb
  begin
    rdMux = '0;
    if (hitMisc)
    begin
      rdMux = miscControl & MISC_WRITABLE;
    end
    else if (hitAnt)
    begin
      rdMux[BIT_ANT_RX_ERROR] = antRxError;
      rdMux[BIT_ANT_RX_BUSY] = (rxState == RX_LISTEN);
    end
    else if (hitRaw)
    begin
      rdMux = eventRawStatus & EVENT_BITS;
    end
    else if (hitStat)
    begin
      rdMux = eventStatus;
    end
    else if (hitMask)
    begin
      rdMux = eventMask & EVENT_BITS;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      ackPhase <= 1'b0;
    end
    else
    begin
      ackPhase <= accessCycle & ~ackPhase;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      prdata <= '0;
      pslverr <= 1'b0;
    end
    else if (accessCycle & ~ackPhase)
    begin
      prdata <= {{(DATA_W-REG_W){1'b0}}, rdMux};
      pslverr <= ~addrHit;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      miscControl <= MISC_RESET;
    end
    else if (wrEn & hitMisc)
    begin
      miscControl <= apbReq.pwdata[REG_W-1:0] & MISC_WRITABLE;
    end
  end

  assign codeMemorySel = miscControl[BIT_CODE_MEMORY_SEL];
  assign microSoftReset = miscControl[BIT_MICRO_SOFT_RESET];

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      eventMask <= EVENT_RESET;
    end
    else if (wrEn & hitMask)
    begin
      eventMask <= apbReq.pwdata[REG_W-1:0] & EVENT_BITS;
    end
  end

  // A reply is tracked from the end of a transmission until a full word or timeout.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rxState <= RX_IDLE;
    end
    else
    begin
      case (rxState)
        RX_IDLE:
        begin
          if (evtIn.antTxDone)
          begin
            rxState <= RX_LISTEN;
          end
        end
        RX_LISTEN:
        begin
          if (rxCompleteEv | rxTimeoutEv)
          begin
            rxState <= RX_IDLE;
          end
        end
        default:
        begin
          rxState <= RX_IDLE;
        end
      endcase
    end
  end

  // A fresh transmission restarts the bit count and the timeout.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      rxBitCount <= BIT_NONE;
    end
    else if (evtIn.antTxDone | rxState != RX_LISTEN)
    begin
      rxBitCount <= BIT_NONE;
    end
    else if (evtIn.antRxBit)
    begin
      rxBitCount <= rxBitCount + RX_CNT_W'(1);
    end
  end

  // The millisecond tick is an enable pulse; it keeps the 100 ms counter narrow.
  assign msTick = (rxState == RX_LISTEN) && (msDiv == DIV_LAST);
  assign timeoutHit = msTick && (msCount == TICK_LAST);

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      msDiv <= '0;
      msCount <= '0;
    end
    else if (evtIn.antTxDone | rxState != RX_LISTEN)
    begin
      msDiv <= '0;
      msCount <= '0;
    end
    else if (msTick)
    begin
      msDiv <= '0;
      msCount <= msCount + TICK_CNT_W'(1);
    end
    else
    begin
      msDiv <= msDiv + DIV_W'(1);
    end
  end

  assign rxCompleteEv = (rxState == RX_LISTEN) & ~evtIn.antTxDone & evtIn.antRxBit
    & (rxBitCount == BIT_LAST);
  assign rxTimeoutEv = timeoutHit & ~evtIn.antTxDone & ~rxCompleteEv;
  assign rxTruncEv = rxTimeoutEv & (rxBitCount != BIT_NONE);
  assign tunerDoneEv = evtIn.tunerXferEnd & ~evtIn.tunerXferFail;
  assign tunerErrorEv = evtIn.tunerXferEnd & evtIn.tunerXferFail;

  always_comb
  begin
    eventSet = '0;
    eventSet[EV_ANT_RX_COMPLETE] = rxCompleteEv;
    eventSet[EV_ANT_TX_COMPLETE] = evtIn.antTxDone;
    eventSet[EV_ANT_RX_TIMEOUT] = rxTimeoutEv;
    eventSet[EV_TUNER_XFER_ERROR] = tunerErrorEv;
    eventSet[EV_TUNER_XFER_DONE] = tunerDoneEv;
  end

  // Raw bits ignore the mask, and a same-cycle event outranks the clear.
  always_comb
  begin
    next_eventRawStatus = eventRawStatus;
    if (wrEn & hitClr)
    begin
      next_eventRawStatus = eventRawStatus & ~apbReq.pwdata[REG_W-1:0];
    end
    next_eventRawStatus = (next_eventRawStatus | eventSet) & EVENT_BITS;
  end

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      eventRawStatus <= EVENT_RESET;
    end
    else
    begin
      eventRawStatus <= next_eventRawStatus;
    end
  end

  assign antClearErr = wrEn & hitAnt & apbReq.pwdata[BIT_ANT_RX_ERROR];

  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      antRxError <= 1'b0;
    end
    else if (rxTruncEv)
    begin
      antRxError <= 1'b1;
    end
    else if (antClearErr)
    begin
      antRxError <= 1'b0;
    end
  end

  assign eventStatus = eventRawStatus & eventMask;
  assign irqActive = |eventStatus;

  // Active low is open drain so several devices can share one wired line.
  always_ff @(posedge ref_clk)
  begin
    if (!reset_n)
    begin
      irqOutPin <= 1'b0;
      irqOutPinOe <= 1'b0;
    end
    else if (miscControl[BIT_IRQ_POLARITY_SEL])
    begin
      irqOutPin <= irqActive;
      irqOutPinOe <= 1'b1;
    end
    else
    begin
      irqOutPin <= 1'b0;
      irqOutPinOe <= irqActive;
    end
  end

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_clear_write;
    wrEn && hitClr;
  endsequence
  sequence s_truncated_timeout;
    rxTimeoutEv && rxBitCount != BIT_NONE;
  endsequence

  a_pin_never_high: assert property (
    !miscControl[BIT_IRQ_POLARITY_SEL] |=> !(irqOutPinOe && irqOutPin))
    else $error("Request pin driven high in active-low mode.");
  // The pin register used the polarity of the previous cycle, so compare against that.
  a_irq_tracks_status: assert property (
    ##1 irqOutPinOe == ($past(miscControl[BIT_IRQ_POLARITY_SEL]) ? 1'b1 : $past(irqActive)))
    else $error("Request pin enable does not follow the status.");
  a_irq_level_high: assert property (
    miscControl[BIT_IRQ_POLARITY_SEL] |=> irqOutPin == $past(|(eventRawStatus & eventMask)))
    else $error("Active-high request pin wrong.");
  a_raw_clear_only: assert property (
    $fell(eventRawStatus[EV_TUNER_XFER_DONE])
    |-> $past(wrEn && hitClr && apbReq.pwdata[EV_TUNER_XFER_DONE]))
    else $error("Raw bit dropped without a clear write.");
  a_set_beats_clear: assert property (
    s_clear_write and (eventSet != 8'h00)
    |=> (eventRawStatus & $past(eventSet)) == $past(eventSet))
    else $error("Clear won over a same-cycle event.");
  a_reserved_zero: assert property (
    (eventRawStatus & ~EVENT_BITS) == 8'h00 && (miscControl & ~MISC_WRITABLE) == 8'h00)
    else $error("Reserved bit set.");
  a_rx_full_word: assert property (
    $rose(eventRawStatus[EV_ANT_RX_COMPLETE])
    |-> $past(rxBitCount) == BIT_LAST && $past(evtIn.antRxBit))
    else $error("Receive-complete without a full word.");
  a_timeout_at_100: assert property (
    rxTimeoutEv |-> msCount == TICK_LAST && msDiv == DIV_LAST && !rxCompleteEv)
    else $error("Timeout at the wrong count.");
  a_trunc_sets_err: assert property (
    s_truncated_timeout |=> antRxError && eventRawStatus[EV_ANT_RX_TIMEOUT])
    else $error("Truncated reply did not flag the error.");
  a_tuner_exclusive: assert property (
    evtIn.tunerXferEnd && evtIn.tunerXferFail |=> eventRawStatus[EV_TUNER_XFER_ERROR]
    && ($past(eventRawStatus[EV_TUNER_XFER_DONE]) || !eventRawStatus[EV_TUNER_XFER_DONE]))
    else $error("Tuner failure set the done bit.");
  a_status_masked: assert property (eventStatus == (eventRawStatus & eventMask))
    else $error("Status is not raw AND mask.");
  a_soft_reset_hold: assert property (
    microSoftReset && !(wrEn && hitMisc) |=> microSoftReset)
    else $error("Soft reset released without a write.");
  a_txct_sets: assert property (evtIn.antTxDone |=> eventRawStatus[EV_ANT_TX_COMPLETE])
    else $error("Transmit-complete not set.");
endmodule
`default_nettype wire

// [inc/esmc_pkg.sv]
// Package of register map, field positions and carrier types for the event status block.
`default_nettype none
package esmc_pkg;
  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0] IDX_MISC_CONTROL = 8'hee;
  localparam logic [7:0] IDX_ANT_STATUS = 8'hf0;
  localparam logic [7:0] IDX_EVENT_RAW_STATUS = 8'hf9;
  localparam logic [7:0] IDX_EVENT_STATUS = 8'hfb;
  localparam logic [7:0] IDX_EVENT_MASK = 8'hfd;
  localparam logic [7:0] IDX_EVENT_CLEAR = 8'hff;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int REG_W = 8;
  localparam logic [1:0] WORD_ALIGN = 2'h0;
  // Control register fields.
  localparam int BIT_IRQ_POLARITY_SEL = 2;
  localparam int BIT_CODE_MEMORY_SEL = 1;
  localparam int BIT_MICRO_SOFT_RESET = 0;
  localparam logic [7:0] MISC_WRITABLE = 8'h07;
  localparam logic [7:0] MISC_RESET = 8'h00;
  // Event bit positions shared by raw status, status, mask and clear.
  localparam int EV_ANT_RX_COMPLETE = 5;
  localparam int EV_ANT_TX_COMPLETE = 4;
  localparam int EV_ANT_RX_TIMEOUT = 3;
  localparam int EV_TUNER_XFER_ERROR = 1;
  localparam int EV_TUNER_XFER_DONE = 0;
  localparam logic [7:0] EVENT_BITS = 8'h3b;
  localparam logic [7:0] EVENT_RESET = 8'h00;
  // Antenna status register fields.
  localparam int BIT_ANT_RX_ERROR = 0;
  localparam int BIT_ANT_RX_BUSY = 1;
  // Antenna reply framing and timing.
  localparam int RX_WORD_BITS = 10;
  localparam int RX_CNT_W = 4;
  localparam int CLK_HZ = 125_000_000;
  localparam int MS_PER_SECOND = 1000;
  localparam int RX_TIMEOUT_MS = 100;
  localparam int TICK_CNT_W = 7;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } esmc_apb_req_s;

  typedef struct packed {
    logic tunerXferEnd;
    logic tunerXferFail;
    logic antTxDone;
    logic antRxBit;
  } esmc_evt_s;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b01,
    RX_LISTEN = 2'b10
  } esmc_rx_state_e;
endpackage
`default_nettype wire

// [sim/esmc_irq_line.sv]
// Board-side model of the shared interrupt request line with its pull-up.
`default_nettype none
module esmc_irq_line
(
  input wire logic pinOut,
  input wire logic pinOe,
  output logic irqLine
);
  timeunit 1ns;
  timeprecision 1ps;
  // A released line is pulled high, so an undriven pin must never read as low.
  assign irqLine = pinOe ? pinOut : 1'b1;
endmodule
`default_nettype wire

// [sim/tb_event_status_and_misc_control.sv]
// Self-checking testbench of the event status and miscellaneous control block.
`default_nettype none
module tb_event_status_and_misc_control;
  import esmc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  // A short millisecond keeps the reply timeout near a thousand cycles.
  localparam int CPM = 10;
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0;
  esmc_apb_req_s apbReq = '0;
  esmc_evt_s evtIn = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, irqOutPin, irqOutPinOe, codeMemorySel, microSoftReset;
  logic antRxError, irqLine, err;
  logic [31:0] rd;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #4 ref_clk = ~ref_clk;

  esmc_event_ctrl #(.CYC_PER_MS(CPM)) u_esmc_event_ctrl (.ref_clk(ref_clk), .reset_n(reset_n),
    .apbReq(apbReq), .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtIn(evtIn),
    .irqOutPin(irqOutPin), .irqOutPinOe(irqOutPinOe), .codeMemorySel(codeMemorySel),
    .microSoftReset(microSoftReset), .antRxError(antRxError));
  esmc_irq_line u_esmc_irq_line (.pinOut(irqOutPin), .pinOe(irqOutPinOe), .irqLine(irqLine));

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    cmp_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, got, exp);
    end
  endtask

  // Request stays put until pready is seen high; data is taken at that edge.
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    @(posedge ref_clk);
    apbReq.psel <= 1'b1;
    apbReq.penable <= 1'b0;
    apbReq.pwrite <= w;
    apbReq.paddr <= {2'h0, idx, 2'h0};
    apbReq.pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    // The wait has no limit of its own; only the bench timeout ends it.
    do
      @(posedge ref_clk);
    while (pready !== 1'b1);
    chk({31'h0, pready}, 32'h1, "no ready");
    rd = prdata;
    err = pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk({err, rd[30:0]}, {24'h0, exp}, "read");
  endtask

  // Bits are end, fail, transmit done, reply bit.
  task automatic pulse(input logic [3:0] v);
    @(posedge ref_clk);
    evtIn <= esmc_evt_s'(v);
    @(posedge ref_clk);
    evtIn <= '0;
  endtask

  task automatic pin(input logic [2:0] exp, input string msg);
    repeat (3) @(posedge ref_clk);
    chk({29'h0, irqOutPinOe, irqOutPin, irqLine}, {29'h0, exp}, msg);
  endtask

  task automatic t_reset();
    chk({30'h0, codeMemorySel, microSoftReset}, 32'h0, "reset pins");
    pin(3'b001, "reset irq");
    rdc(IDX_MISC_CONTROL, 8'h00);
    rdc(IDX_EVENT_RAW_STATUS, 8'h00);
    rdc(IDX_EVENT_MASK, 8'h00);
    $display("test reset done");
  endtask

  task automatic t_misc();
    apb(1'b1, IDX_MISC_CONTROL, 8'hff);
    rdc(IDX_MISC_CONTROL, 8'h07);
    chk({30'h0, codeMemorySel, microSoftReset}, 32'h3, "ctrl set");
    pin(3'b100, "high idle");
    apb(1'b1, IDX_MISC_CONTROL, 8'h02);
    rdc(IDX_MISC_CONTROL, 8'h02);
    chk({30'h0, codeMemorySel, microSoftReset}, 32'h2, "ctrl clr");
    apb(1'b1, IDX_EVENT_RAW_STATUS, 8'hff);
    rdc(IDX_EVENT_RAW_STATUS, 8'h00);
    apb(1'b0, 8'h10, 8'h00);
    chk({31'h0, err}, 32'h1, "unmapped");
    apb(1'b1, IDX_MISC_CONTROL, 8'h00);
    $display("test misc done");
  endtask

  task automatic t_tuner();
    pulse(4'h8);
    rdc(IDX_EVENT_RAW_STATUS, 8'h01);
    apb(1'b1, IDX_EVENT_CLEAR, 8'h00);
    rdc(IDX_EVENT_RAW_STATUS, 8'h01);
    apb(1'b1, IDX_EVENT_CLEAR, 8'h01);
    rdc(IDX_EVENT_RAW_STATUS, 8'h00);
    pulse(4'hc);
    rdc(IDX_EVENT_RAW_STATUS, 8'h02);
    // A new error lands on the same edge as the write that clears it, so it must survive.
    fork
      apb(1'b1, IDX_EVENT_CLEAR, 8'h02);
      begin
        repeat (3) @(posedge ref_clk);
        evtIn <= esmc_evt_s'(4'hc);
        @(posedge ref_clk);
        evtIn <= '0;
      end
    join
    rdc(IDX_EVENT_RAW_STATUS, 8'h02);
    $display("test tuner done");
  endtask

  task automatic t_irq();
    pin(3'b001, "masked");
    apb(1'b1, IDX_EVENT_MASK, 8'h3b);
    rdc(IDX_EVENT_STATUS, 8'h02);
    pin(3'b100, "low active");
    apb(1'b1, IDX_MISC_CONTROL, 8'h04);
    pin(3'b111, "high active");
    apb(1'b1, IDX_EVENT_CLEAR, 8'h02);
    rdc(IDX_EVENT_STATUS, 8'h00);
    pin(3'b100, "high inactive");
    apb(1'b1, IDX_MISC_CONTROL, 8'h00);
    pin(3'b001, "low released");
    $display("test irq done");
  endtask

  task automatic t_ant();
    pulse(4'h2);
    rdc(IDX_EVENT_RAW_STATUS, 8'h10);
    repeat (10) pulse(4'h1);
    rdc(IDX_EVENT_RAW_STATUS, 8'h30);
    chk({31'h0, antRxError}, 32'h0, "rx clean");
    apb(1'b1, IDX_EVENT_CLEAR, 8'h3b);
    pulse(4'h2);
    repeat (9) pulse(4'h1);
    repeat (900) @(posedge ref_clk);
    rdc(IDX_EVENT_RAW_STATUS, 8'h10);
    repeat (200) @(posedge ref_clk);
    rdc(IDX_EVENT_RAW_STATUS, 8'h18);
    chk({31'h0, antRxError}, 32'h1, "truncated");
    rdc(IDX_ANT_STATUS, 8'h01);
    apb(1'b1, IDX_ANT_STATUS, 8'h01);
    apb(1'b1, IDX_EVENT_CLEAR, 8'hff);
    pulse(4'h2);
    repeat (1100) @(posedge ref_clk);
    rdc(IDX_EVENT_RAW_STATUS, 8'h18);
    chk({31'h0, antRxError}, 32'h0, "silent");
    $display("test antenna done");
  endtask

  // Ceiling well above the roughly two and a half thousand cycles the tests need.
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      num_errors++;
      $display("[FAIL] %0t timeout", $time);
      stop_test();
    end
  end

  initial
  begin
    repeat (5) @(posedge ref_clk);
    reset_n <= 1'b1;
    t_reset();
    t_misc();
    t_tuner();
    t_irq();
    t_ant();
    stop_test();
  end
endmodule
`default_nettype wire
